/* verilog/spf_consts.vh */
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH
// How it works
// - Send bytes queue in one 2048-byte FIFO, shifted out in order.
// - Received bytes queue in one 2048-byte FIFO for later reads.
// - Selected protocol framing is added by hardware, never by software.
// - ASCII and start/end need no acknowledge; 3964R and master-slave do.
// - Send status read reports latest partner acknowledge state.
// - Bit rate up to 115 kBaud via programmable divider.
// - Full duplex four-wire or half duplex two-wire with driver enable.
// - ASCII mode stores received bytes masked to the set width, sends no acknowledge.
// - ASCII reads return what is buffered now; no concatenation.
// - Start/end payload range by width: 6b 20-3F, 7b 20-7F, 8b 20-FF.
// - Start/end frame delivered only after complete end identifier.
// - Start/end transmit prepends start and appends end identifiers.
// - Start and end identifier counts each 0, 1 or 2.
// - Without end identifier, deliver on inter-character gap timeout.
// - Identifier values 01h..1Fh valid; above 1Fh never match an end identifier on receive but are still sent.
// - 3964R uses STX, DLE, ETX and BCC control characters; any reply other than DLE counts as NAK.
// - 3964R message carries at most 255 payload bytes.
// - 3964R doubles payload DLE on send and collapses pairs on receive.
// - On 3964R collision the lower-priority station holds off.
`define SPF_A_CTRL   8'h00
`define SPF_A_IDS    8'h04
`define SPF_A_BAUD   8'h08
`define SPF_A_GAP    8'h0C
`define SPF_A_TXD    8'h10
`define SPF_A_RXD    8'h14
`define SPF_A_STAT   8'h18
`define SPF_A_SEND   8'h1C
`define SPF_M_ASCII  2'h0
`define SPF_M_STXETX 2'h1
`define SPF_M_3964   2'h2
`define SPF_M_MS     2'h3
`define SPF_STX      8'h02
`define SPF_ETX      8'h03
`define SPF_DLE      8'h10
`define SPF_NAK      8'h15
`define SPF_ID_MAX   8'h1F
`define SPF_PAY_MIN  8'h20
`define SPF_MAX_3964 11'h0FF
`define SPF_BAUD_RST 16'h01B2
`define SPF_GAP_RST  16'h0020
`define SPF_OKAY     2'h0
`define SPF_SLVERR   2'h2
`endif

/* verilog/spf_framer.v */
`include "spf_consts.vh"
// Serial point-to-point framer with AXI4-Lite registers
module spf_framer #(
	parameter AW = 11,
	parameter DEPTH = 2048
) (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        line_rxd,
	output reg         line_txd,
	output reg         line_drv_en
);
	localparam TX_IDLE = 3'h0;
	localparam TX_SID  = 3'h1;
	localparam TX_DATA = 3'h2;
	localparam TX_EID  = 3'h3;
	localparam TX_BCC  = 3'h4;
	localparam TX_WACK = 3'h5;

	reg [7:0]    txm [0:DEPTH-1];
	reg [7:0]    rxm [0:DEPTH-1];
	reg [AW:0]   txw_r, txr_r, rxw_r, rxr_r, rxc_r;
	reg [1:0]    mode_r;
	reg          half_r, prio_r;
	reg [1:0]    wid_r;
	reg [1:0]    nsid_r, neid_r;
	reg [7:0]    sid0_r, sid1_r, eid0_r, eid1_r;
	reg [15:0]   baud_r, gap_r;
	reg [10:0]   slen_r, scnt_r;
	reg          busy_r, ack_r, nak_r, err_r, ovf_r;
	reg [2:0]    ts_r;
	reg [1:0]    idx_r;
	reg [7:0]    bcc_r;
	reg          dle_pend_r;
	// Serialiser
	reg [9:0]    tsh_r;
	reg [3:0]    tbit_r;
	reg [15:0]   tdiv_r;
	reg          tgo;
	reg [7:0]    tbyte;
	// Deserialiser
	reg [1:0]    rs_r;
	reg [7:0]    rsh_r;
	reg [3:0]    rbit_r;
	reg [15:0]   rdiv_r;
	reg          rdone_r;
	reg [15:0]   gapc_r;
	reg [1:0]    eseen_r;
	reg          rdle_r;

	function [7:0] id_ok;
		input [7:0] v;
		id_ok = (v != 8'h00 && v <= `SPF_ID_MAX) ? 8'h01 : 8'h00;
	endfunction

	function [7:0] wmask;
		input [1:0] w;
		wmask = (w == 2'h1) ? 8'h3F : (w == 2'h2) ? 8'h7F : 8'hFF;
	endfunction

	// AXI write: address and data taken together
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	wire rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	wire tx_full = (txw_r - txr_r) == DEPTH[AW:0];
	wire [AW:0] tx_lvl = txw_r - txr_r;
	wire [AW:0] rx_lvl = rxc_r - rxr_r;
	// Baud register holds clocks per bit
	wire [15:0] bit_last = baud_r - 16'h0001;
	wire rx_empty = rxc_r == rxr_r;
	wire tx_empty = txw_r == txr_r;
	wire send_req = wr_go && s_axi_awaddr == `SPF_A_SEND && !busy_r;
	wire [10:0] req_len = s_axi_wdata[10:0];
	wire too_long = mode_r == `SPF_M_3964 && req_len > `SPF_MAX_3964;
	wire [7:0] rx_ch = rsh_r & wmask(wid_r);
	wire [7:0] eid_cur = (eseen_r == 2'h0) ? eid0_r : eid1_r;

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SPF_OKAY;
			mode_r <= `SPF_M_ASCII;
			half_r <= 1'b0;
			prio_r <= 1'b0;
			wid_r  <= 2'h3;
			nsid_r <= 2'h0;
			neid_r <= 2'h0;
			sid0_r <= 8'hFF;
			sid1_r <= 8'hFF;
			eid0_r <= 8'hFF;
			eid1_r <= 8'hFF;
			baud_r <= `SPF_BAUD_RST;
			gap_r  <= `SPF_GAP_RST;
			txw_r  <= {(AW+1){1'b0}};
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SPF_OKAY;
				case (s_axi_awaddr)
				`SPF_A_CTRL: begin
					mode_r <= s_axi_wdata[1:0];
					half_r <= s_axi_wdata[2];
					prio_r <= s_axi_wdata[3];
					wid_r  <= s_axi_wdata[5:4];
					nsid_r <= (s_axi_wdata[7:6] == 2'h3) ? 2'h2 : s_axi_wdata[7:6];
					neid_r <= (s_axi_wdata[9:8] == 2'h3) ? 2'h2 : s_axi_wdata[9:8];
				end
				`SPF_A_IDS: begin
					// Slots kept as written; end slots outside 01h..1Fh never match on receive
					sid0_r <= s_axi_wdata[7:0];
					sid1_r <= s_axi_wdata[15:8];
					eid0_r <= s_axi_wdata[23:16];
					eid1_r <= s_axi_wdata[31:24];
				end
				`SPF_A_BAUD: baud_r <= (s_axi_wdata[15:0] == 16'h0000) ? 16'h0001
					: s_axi_wdata[15:0];
				`SPF_A_GAP:  gap_r <= s_axi_wdata[15:0];
				`SPF_A_TXD: begin
					if (tx_full)
						s_axi_bresp <= `SPF_SLVERR;
					else if (s_axi_wstrb[0]) begin
						txm[txw_r[AW-1:0]] <= s_axi_wdata[7:0];
						txw_r <= txw_r + 1'b1;
					end
				end
				`SPF_A_SEND: if (busy_r || too_long)
					s_axi_bresp <= `SPF_SLVERR;
				`SPF_A_STAT, `SPF_A_RXD: s_axi_bresp <= `SPF_SLVERR;
				default: s_axi_bresp <= `SPF_SLVERR;
				endcase
			end
		end
	end

	// AXI read
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SPF_OKAY;
			rxr_r <= {(AW+1){1'b0}};
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SPF_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				case (s_axi_araddr)
				`SPF_A_CTRL: s_axi_rdata <= {22'h0, neid_r, nsid_r, wid_r, prio_r, half_r, mode_r};
				`SPF_A_IDS:  s_axi_rdata <= {eid1_r, eid0_r, sid1_r, sid0_r};
				`SPF_A_BAUD: s_axi_rdata <= {16'h0, baud_r};
				`SPF_A_GAP:  s_axi_rdata <= {16'h0, gap_r};
				`SPF_A_RXD: begin
					// Bit 8 marks a valid byte; empty reads return zero
					if (!rx_empty) begin
						s_axi_rdata <= {23'h0, 1'b1, rxm[rxr_r[AW-1:0]]};
						rxr_r <= rxr_r + 1'b1;
					end
				end
				`SPF_A_STAT: s_axi_rdata <= {rx_lvl, tx_lvl, 3'h0,
					ovf_r, err_r, nak_r, ack_r, busy_r};
				`SPF_A_SEND: s_axi_rdata <= {21'h0, slen_r};
				default: s_axi_rresp <= `SPF_SLVERR;
				endcase
			end
		end
	end

	// Priority hold-off while partner frame incoming
	wire tgo_hold = (ts_r == TX_SID) && mode_r == `SPF_M_3964 && !prio_r && rs_r != 2'h0;
	wire ctrl_frm = mode_r == `SPF_M_STXETX || mode_r == `SPF_M_3964;

	// Byte source for the framing sequencer
	always @* begin
		tgo = 1'b0;
		tbyte = 8'h00;
		if (tbit_r == 4'h0 && !tgo_hold) begin
			case (ts_r)
			TX_SID: begin
				tgo = 1'b1;
				tbyte = (mode_r == `SPF_M_3964) ? `SPF_STX : (idx_r == 2'h0 ? sid0_r : sid1_r);
			end
			TX_DATA: if (scnt_r != slen_r && !tx_empty) begin
				tgo = 1'b1;
				tbyte = dle_pend_r ? `SPF_DLE : txm[txr_r[AW-1:0]];
			end
			TX_EID: begin
				tgo = 1'b1;
				tbyte = (mode_r == `SPF_M_3964) ? (idx_r == 2'h0 ? `SPF_DLE : `SPF_ETX)
					: (idx_r == 2'h0 ? eid0_r : eid1_r);
			end
			TX_BCC: begin
				tgo = 1'b1;
				tbyte = bcc_r;
			end
			default: tgo = 1'b0;
			endcase
		end
	end
	// Framing sequencer and serialiser
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ts_r <= TX_IDLE;
			busy_r <= 1'b0;
			ack_r <= 1'b0;
			nak_r <= 1'b0;
			err_r <= 1'b0;
			slen_r <= 11'h000;
			scnt_r <= 11'h000;
			idx_r <= 2'h0;
			bcc_r <= 8'h00;
			dle_pend_r <= 1'b0;
			txr_r <= {(AW+1){1'b0}};
			tsh_r <= 10'h3FF;
			tbit_r <= 4'h0;
			tdiv_r <= 16'h0000;
			line_txd <= 1'b1;
			line_drv_en <= 1'b0;
		end else begin
			line_txd <= tsh_r[0];
			line_drv_en <= !half_r || tbit_r != 4'h0;
			if (tbit_r != 4'h0) begin
				if (tdiv_r == bit_last) begin
					tdiv_r <= 16'h0000;
					tsh_r <= {1'b1, tsh_r[9:1]};
					tbit_r <= tbit_r - 1'b1;
				end else
					tdiv_r <= tdiv_r + 1'b1;
			end
			if (tgo) begin
				tsh_r <= {1'b1, tbyte, 1'b0};
				tbit_r <= 4'hA;
				tdiv_r <= 16'h0000;
			end
			if (send_req) begin
				err_r <= too_long;
				if (!too_long) begin
					busy_r <= 1'b1;
					ack_r <= 1'b0;
					nak_r <= 1'b0;
					slen_r <= req_len;
					scnt_r <= 11'h000;
					idx_r <= 2'h0;
					bcc_r <= 8'h00;
					ts_r <= (mode_r == `SPF_M_3964 || (mode_r == `SPF_M_STXETX &&
						nsid_r != 2'h0)) ? TX_SID : TX_DATA;
				end
			end
			case (ts_r)
			// Idle must not override a send started this cycle
			TX_IDLE: begin
			end
			TX_SID: if (tgo) begin
				if (mode_r == `SPF_M_3964 || idx_r + 2'h1 >= nsid_r) begin
					idx_r <= 2'h0;
					ts_r <= TX_DATA;
				end else
					idx_r <= idx_r + 2'h1;
			end
			TX_DATA: if (scnt_r == slen_r || tx_empty) begin
				ts_r <= (ctrl_frm && (mode_r == `SPF_M_3964 || neid_r != 2'h0)) ?
					TX_EID : (mode_r == `SPF_M_MS ? TX_WACK : TX_IDLE);
				if (!(mode_r == `SPF_M_MS))
					busy_r <= ctrl_frm && (mode_r == `SPF_M_3964 || neid_r != 2'h0);
			end else if (tgo) begin
				bcc_r <= bcc_r ^ tbyte;
				if (mode_r == `SPF_M_3964 && tbyte == `SPF_DLE && !dle_pend_r)
					dle_pend_r <= 1'b1;
				else begin
					dle_pend_r <= 1'b0;
					txr_r <= txr_r + 1'b1;
					scnt_r <= scnt_r + 1'b1;
				end
			end
			TX_EID: if (tgo) begin
				bcc_r <= bcc_r ^ tbyte;
				if (idx_r + 2'h1 >= (mode_r == `SPF_M_3964 ? 2'h2 : neid_r)) begin
					idx_r <= 2'h0;
					ts_r <= (mode_r == `SPF_M_3964) ? TX_BCC : TX_IDLE;
					busy_r <= mode_r == `SPF_M_3964;
				end else
					idx_r <= idx_r + 2'h1;
			end
			TX_BCC: if (tgo)
				ts_r <= TX_WACK;
			TX_WACK: if (rdone_r && tbit_r == 4'h0) begin
				ack_r <= rsh_r == `SPF_DLE || mode_r == `SPF_M_MS;
				nak_r <= rsh_r != `SPF_DLE && mode_r != `SPF_M_MS;
				busy_r <= 1'b0;
				ts_r <= TX_IDLE;
			end
			default: ts_r <= TX_IDLE;
			endcase
		end
	end

	// Deserialiser, mid-bit sampling
	wire frame_ok = (eseen_r == neid_r) && neid_r != 2'h0;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			rs_r <= 2'h0;
			rsh_r <= 8'h00;
			rbit_r <= 4'h0;
			rdiv_r <= 16'h0000;
			rdone_r <= 1'b0;
			rxw_r <= {(AW+1){1'b0}};
			rxc_r <= {(AW+1){1'b0}};
			gapc_r <= 16'h0000;
			eseen_r <= 2'h0;
			rdle_r <= 1'b0;
			ovf_r <= 1'b0;
		end else begin
			rdone_r <= 1'b0;
			case (rs_r)
			2'h0: if (!line_rxd) begin
				rs_r <= 2'h1;
				rdiv_r <= {1'b0, baud_r[15:1]};
				rbit_r <= 4'h0;
			end
			2'h1: if (rdiv_r == 16'h0000) begin
				rdiv_r <= bit_last;
				// Done at stop-bit sample, after all eight data bits shifted
				if (rbit_r == 4'h9) begin
					rs_r <= 2'h0;
					rdone_r <= 1'b1;
				end else begin
					if (rbit_r != 4'h0 || line_rxd == 1'b0)
						rbit_r <= rbit_r + 1'b1;
					else
						rs_r <= 2'h0;
					if (rbit_r != 4'h0)
						rsh_r <= {line_rxd, rsh_r[7:1]};
				end
			end else
				rdiv_r <= rdiv_r - 1'b1;
			default: rs_r <= 2'h0;
			endcase
			if (rs_r == 2'h0 && !rdone_r && rxw_r != rxc_r && gap_r != 16'h0000)
				gapc_r <= gapc_r + 1'b1;
			// Gap timeout releases data when no end identifier
			if (mode_r == `SPF_M_STXETX && neid_r == 2'h0 && gapc_r >= gap_r
				&& gap_r != 16'h0000) begin
				rxc_r <= rxw_r;
				gapc_r <= 16'h0000;
			end
			if (rdone_r && ts_r != TX_WACK) begin
				gapc_r <= 16'h0000;
				if ((rxw_r - rxr_r) == DEPTH[AW:0])
					ovf_r <= 1'b1;
				else case (mode_r)
				`SPF_M_STXETX: begin
					if (neid_r != 2'h0 && id_ok(eid_cur) != 8'h00 && rx_ch == eid_cur) begin
						eseen_r <= eseen_r + 2'h1;
						if (eseen_r + 2'h1 == neid_r) begin
							rxc_r <= rxw_r;
							eseen_r <= 2'h0;
						end
					end else if (rx_ch >= `SPF_PAY_MIN) begin
						rxm[rxw_r[AW-1:0]] <= rx_ch;
						rxw_r <= rxw_r + 1'b1;
						eseen_r <= 2'h0;
					end
				end
				`SPF_M_3964: begin
					if (rx_ch == `SPF_DLE && !rdle_r)
						rdle_r <= 1'b1;
					else if (rdle_r && rx_ch == `SPF_ETX) begin
						rdle_r <= 1'b0;
						rxc_r <= rxw_r;
					end else if (rx_ch != `SPF_STX || rdle_r) begin
						rdle_r <= 1'b0;
						rxm[rxw_r[AW-1:0]] <= rx_ch;
						rxw_r <= rxw_r + 1'b1;
					end
				end
				default: begin
					rxm[rxw_r[AW-1:0]] <= rx_ch;
					rxw_r <= rxw_r + 1'b1;
					rxc_r <= rxw_r + 1'b1;
				end
				endcase
			end
			if (frame_ok)
				eseen_r <= 2'h0;
		end
	end
endmodule // spf_framer

/* testbench/spf_partner.sv */
module spf_partner #(
	parameter int BIT = 16
) (
	input  wire logic clk_sys,
	input  wire logic line_txd,
	output logic      line_rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic [7:0] b;
	initial line_rxd = 1'b1;
	// Mid-cell sampling, LSB first
	initial forever begin
		@(negedge line_txd);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_sys);
			b[i] = line_txd;
		end
		repeat (BIT) @(posedge clk_sys);
		got.push_back(b);
	end
	// Start, 8 data, stop; line rests high between frames
	task send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_rxd <= f[i];
			repeat (BIT) @(posedge clk_sys);
		end
	endtask
endmodule // spf_partner

/* testbench/spf_framer_properties.sv */
`include "spf_consts.vh"
module spf_framer_props (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        line_txd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wr_take;
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	chk_write_answer: assert property (wr_take |=> s_axi_bvalid)
		else $error("write not answered next cycle");
	chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer changed before taken");
	chk_write_closes: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not closed");
	chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("address and data ready differ");
	chk_bad_waddr: assert property (wr_take && s_axi_awaddr > `SPF_A_SEND
		|=> s_axi_bresp == `SPF_SLVERR)
		else $error("unmapped write not refused");
	chk_ro_write: assert property (wr_take && (s_axi_awaddr == `SPF_A_STAT
		|| s_axi_awaddr == `SPF_A_RXD) |=> s_axi_bresp == `SPF_SLVERR)
		else $error("read-only write not refused");
	chk_rst_idle: assert property ($fell(sys_rst)
		|-> line_txd && !s_axi_bvalid && !s_axi_rvalid)
		else $error("not idle after reset");
	chk_start_bit: assert property ($fell(line_txd) |=> !line_txd)
		else $error("start bit too short");
endmodule // spf_framer_props
bind spf_framer spf_framer_props spf_framer_props_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .line_txd(line_txd));

/* testbench/test_serial_ptp_protocol_framer.sv */
`include "spf_consts.vh"
module test_serial_ptp_protocol_framer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 16;
	logic        clk_sys = 0, sys_rst = 1, aw_v = 0, aw_r, w_v = 0, w_r, b_v, b_y = 0;
	logic        ar_v = 0, ar_r, r_v, r_y = 0, rxd, txd, den;
	logic [7:0]  aw_a = 0, ar_a = 0;
	logic [31:0] w_d = 0, r_d;
	logic [1:0]  b_r, r_s;
	int          failures = 0, check_count = 0, cyc = 0;
	spf_framer spf_framer_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(aw_a),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_r), .s_axi_bvalid(b_v),
		.s_axi_bready(b_y), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_y),
		.line_rxd(rxd), .line_txd(txd), .line_drv_en(den));
	spf_partner #(.BIT(BIT)) spf_partner_i (.clk_sys(clk_sys), .line_txd(txd), .line_rxd(rxd));
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			wrap_up;
		end
	end
	task wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_y <= 1'b1;
		do @(posedge clk_sys); while (!(aw_r === 1'b1 && w_r === 1'b1));
		aw_v <= 1'b0;
		w_v <= 1'b0;
		do @(posedge clk_sys); while (b_v !== 1'b1);
		chk("bresp", e, b_r);
		b_y <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Ready raised a cycle late so the answer must stand
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
		ar_a <= a;
		ar_v <= 1'b1;
		do @(posedge clk_sys); while (ar_r !== 1'b1);
		ar_v <= 1'b0;
		@(posedge clk_sys);
		r_y <= 1'b1;
		do @(posedge clk_sys); while (r_v !== 1'b1);
		d = r_d;
		e = r_s;
		r_y <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(n, e, d);
	endtask
	task tx(input int n, input logic [63:0] v);
		for (int i = 0; i < n; i++)
			wr(`SPF_A_TXD, {24'h0, v[8*i +: 8]}, `SPF_OKAY);
		wr(`SPF_A_SEND, n, `SPF_OKAY);
	endtask
	task line(input int n, input logic [63:0] v);
		for (int k = 0; k < 20 * BIT * n && spf_partner_i.got.size() < n; k++)
			@(posedge clk_sys);
		for (int i = 0; i < n; i++)
			chk("line", v[8*i +: 8], spf_partner_i.got[i]);
		spf_partner_i.got.delete();
	endtask
	task feed(input int n, input logic [63:0] v);
		for (int i = 0; i < n; i++)
			spf_partner_i.send(v[8*i +: 8]);
		repeat (BIT) @(posedge clk_sys);
	endtask
	task s_regs;
		logic [31:0] d;
		logic [1:0]  r;
		rchk("ids", `SPF_A_IDS, 32'hFFFFFFFF);
		rchk("baud", `SPF_A_BAUD, {16'h0, `SPF_BAUD_RST});
		rchk("gap", `SPF_A_GAP, {16'h0, `SPF_GAP_RST});
		wr(8'h20, 32'h0, `SPF_SLVERR);
		wr(`SPF_A_STAT, 32'h0, `SPF_SLVERR);
		rd(8'h20, d, r);
		chk("rresp", `SPF_SLVERR, r);
		wr(`SPF_A_BAUD, BIT, `SPF_OKAY);
	endtask
	task s_ascii;
		wr(`SPF_A_CTRL, 32'h0, `SPF_OKAY);
		chk("drv_en", 1'b1, den);
		tx(3, 64'h434241);
		line(3, 64'h434241);
		feed(2, 64'h5510);
		rchk("rx0", `SPF_A_RXD, 32'h110);
		rchk("rx1", `SPF_A_RXD, 32'h155);
		rchk("rx2", `SPF_A_RXD, 32'h0);
	endtask
	task s_frame;
		wr(`SPF_A_CTRL, 32'h171, `SPF_OKAY);
		wr(`SPF_A_IDS, 32'hFF03FF02, `SPF_OKAY);
		tx(2, 64'h3130);
		line(4, 64'h03313002);
		feed(3, 64'h424102);
		rchk("early", `SPF_A_RXD, 32'h0);
		feed(1, 64'h03);
		rchk("pay0", `SPF_A_RXD, 32'h141);
		rchk("pay1", `SPF_A_RXD, 32'h142);
		rchk("pay2", `SPF_A_RXD, 32'h0);
		wr(`SPF_A_CTRL, 32'h071, `SPF_OKAY);
		wr(`SPF_A_GAP, 3 * BIT, `SPF_OKAY);
		feed(2, 64'h4602);
		repeat (8 * BIT) @(posedge clk_sys);
		rchk("gap", `SPF_A_RXD, 32'h146);
	endtask
	task s_3964;
		logic [31:0] d;
		logic [1:0]  r;
		wr(`SPF_A_CTRL, 32'h00A, `SPF_OKAY);
		tx(2, 64'h0510);
		line(7, 64'h16031005101002);
		rd(`SPF_A_STAT, d, r);
		chk("busy", 1'b1, d[0]);
		feed(1, `SPF_DLE);
		rd(`SPF_A_STAT, d, r);
		chk("ack", 2'b10, d[1:0]);
		wr(`SPF_A_SEND, 32'd256, `SPF_SLVERR);
		rd(`SPF_A_STAT, d, r);
		chk("err", 1'b1, d[3]);
	endtask
	task s_ms;
		logic [31:0] d;
		logic [1:0]  r;
		wr(`SPF_A_CTRL, 32'h007, `SPF_OKAY);
		tx(1, 64'h5A);
		line(1, 64'h5A);
		feed(1, 64'h77);
		rd(`SPF_A_STAT, d, r);
		chk("ms_ack", 1'b1, d[1]);
		chk("drv_off", 1'b0, den);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		s_regs;
		s_ascii;
		s_frame;
		s_3964;
		s_ms;
		wrap_up;
	end
endmodule // test_serial_ptp_protocol_framer
